// [design/prs_pulse_scaler.sv]
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
//
// Behaviour
// RQ1: primary numerator 1..65535, resets to 4
// RQ2: primary denominator 1..65535, resets to 1
// RQ3: scaling only in position control mode
// RQ4: initialise loads numerator with encoder counts
// RQ5: host keeps denominator within encoder resolution
// RQ6: position error held in whole counts
// RQ7: clear zeroes command, feedback, error, encoder counters
// RQ8: clear once, on the falling edge
// RQ9: clear input chosen among sequence inputs
// RQ10: inhibit holds command counter in position mode
// RQ11: inhibited pulses are dropped, never replayed
// RQ12: inhibit takes effect about 10 ms later
// RQ13: ratio select off uses primary pair
// RQ14: ratio select on uses secondary pair
// RQ15: policy gates primary changes on servo state
// RQ16: secondary pair 1..65535, defaults 4 and 1
// RQ17: accumulate numerator, emit per denominator, keep remainder
// RQ18: single clock, synchronous reset loads all reset values
module prs_pulse_scaler
  import prs_pkg::*;
#(
  parameter int SEQ_N = 8,
  parameter int COMMAND_PULSE_INHIBIT_INPUT_CYC = prs_pkg::COMMAND_PULSE_INHIBIT_INPUT_DELAY_CYC,
  parameter logic [15:0] ENC_COUNTS = prs_pkg::ENC_COUNTS_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire prs_pkg::prs_apb_req_t apb_req_i,
  output prs_pkg::prs_apb_rsp_t apb_rsp_o,
  input wire logic cmd_pulse_i,
  input wire logic cmd_dir_i,
  input wire logic fb_pulse_i,
  input wire logic fb_dir_i,
  input wire logic pos_mode_i,
  input wire logic servo_on_i,
  input wire logic command_pulse_inhibit_input_i,
  input wire logic ratio_set_select_i,
  input wire logic [SEQ_N-1:0] seq_in_i,
  output logic pos_count_pulse_o,
  output logic pos_count_dir_o,
  output logic [prs_pkg::CNT_W-1:0] pos_error_o,
  output logic inhibit_active_o
);
  import prs_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ONE = 32'h00000001;

  // ratio parameters
  logic [NUM_W-1:0] pend_pri_num; // primary as written
  logic [NUM_W-1:0] pend_pri_den;
  logic [NUM_W-1:0] pri_num; // primary in use
  logic [NUM_W-1:0] pri_den;
  logic [NUM_W-1:0] sec_num;
  logic [NUM_W-1:0] sec_den;
  logic ratio_update_policy;
  logic [SEL_W-1:0] clear_input_assignment;
  logic [NUM_W-1:0] next_pend_pri_num;
  logic [NUM_W-1:0] next_pend_pri_den;
  logic [NUM_W-1:0] next_pri_num;
  logic [NUM_W-1:0] next_pri_den;
  logic [NUM_W-1:0] next_sec_num;
  logic [NUM_W-1:0] next_sec_den;
  logic next_policy;
  logic [SEL_W-1:0] next_clr_sel;

  // position counters, all in whole counts
  logic [CNT_W-1:0] cmd_cnt;
  logic [CNT_W-1:0] fb_cnt;
  logic [CNT_W-1:0] enc_cnt; // encoder_feedback_count_monitor
  logic [CNT_W-1:0] next_cmd_cnt;
  logic [CNT_W-1:0] next_fb_cnt;
  logic [CNT_W-1:0] next_enc_cnt;
  logic [CNT_W-1:0] next_err;

  // clear edge detection
  logic clr_prev;
  logic clr_level;
  logic clr_fall;

  // apb answer
  logic [DW-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [DW-1:0] rd_data;
  logic addr_hit;

  // datapath wires
  logic command_pulse_inhibit_input_dly;
  logic command_pulse_inhibit_input_on;
  logic cmd_take;
  logic use_sec;
  logic [NUM_W-1:0] act_num;
  logic [NUM_W-1:0] act_den;
  logic gear_pulse;
  logic gear_dir;
  logic wr_en;
  logic init_cmd;
  logic apply_ok;
  logic [15:0] wval;
  logic wval_ok;
  logic next_command_pulse_inhibit_input_active;

  // inhibit settles for about 10 ms before acting
  prs_level_delay #(
    .DELAY_CYC(COMMAND_PULSE_INHIBIT_INPUT_CYC)
  ) u_command_pulse_inhibit_input_delay (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(command_pulse_inhibit_input_i),
    .level_o(command_pulse_inhibit_input_dly)
  ); // RQ12

  // inhibit only matters in position control mode
  assign command_pulse_inhibit_input_on = command_pulse_inhibit_input_dly & pos_mode_i; // RQ10

  // selected sequence input carries the clear
  assign clr_level = seq_in_i[clear_input_assignment]; // RQ9
  assign clr_fall = clr_prev & ~clr_level; // RQ8

  // pulses outside position mode or while inhibited are simply lost
  assign cmd_take = cmd_pulse_i & pos_mode_i & ~command_pulse_inhibit_input_on & ~clr_fall; // RQ3 RQ11

  // pair select follows the input directly in position mode
  assign use_sec = pos_mode_i & ratio_set_select_i; // RQ14
  assign act_num = use_sec ? sec_num : pri_num; // RQ13
  assign act_den = use_sec ? sec_den : pri_den; // RQ13

  prs_gear_accum #(
    .NUM_W(NUM_W),
    .ACC_W(ACC_W)
  ) u_gear (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pulse_i(cmd_take),
    .dir_i(cmd_dir_i),
    .num_i(act_num),
    .den_i(act_den),
    .clr_i(clr_fall),
    .cnt_pulse_o(gear_pulse),
    .cnt_dir_o(gear_dir)
  );

  // bus decode
  assign wr_en = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & apb_rsp_o.pready;
  assign wval = apb_req_i.pwdata[15:0];
  // zero is outside 1..65535, such a write leaves the value alone
  assign wval_ok = (wval != 16'h0000); // RQ1 RQ2 RQ16
  assign init_cmd = wr_en & (apb_req_i.paddr == OFS_CTRL)
    & apb_req_i.pwdata[CTRL_INIT_BIT];
  // primary changes wait for servo off unless policy allows
  assign apply_ok = ratio_update_policy | ~servo_on_i; // RQ15

  // parameter registers
  always_comb begin
    next_pend_pri_num = pend_pri_num;
    next_pend_pri_den = pend_pri_den;
    next_sec_num = sec_num;
    next_sec_den = sec_den;
    next_policy = ratio_update_policy;
    next_clr_sel = clear_input_assignment;
    if (wr_en) begin
      case (apb_req_i.paddr)
        OFS_CTRL: begin
          next_policy = apb_req_i.pwdata[CTRL_POLICY_BIT]; // RQ15
        end
        OFS_PRI_NUM: begin
          if (wval_ok) next_pend_pri_num = wval; // RQ1
        end
        OFS_PRI_DEN: begin
          if (wval_ok) next_pend_pri_den = wval; // RQ2
        end
        OFS_SEC_NUM: begin
          if (wval_ok) next_sec_num = wval; // RQ16
        end
        OFS_SEC_DEN: begin
          if (wval_ok) next_sec_den = wval; // RQ16
        end
        OFS_CLR_SEL: begin
          next_clr_sel = apb_req_i.pwdata[SEL_W-1:0]; // RQ9
        end
        default: begin
          next_policy = ratio_update_policy;
        end
      endcase
    end
    // initialise wins over a plain write in the same cycle
    if (init_cmd) begin
      next_pend_pri_num = ENC_COUNTS; // RQ4
      next_pend_pri_den = DEN_RST;
      next_sec_num = NUM_RST;
      next_sec_den = DEN_RST;
      next_policy = POLICY_RST;
    end
    // a held-back value lands as soon as the servo goes off
    next_pri_num = apply_ok ? next_pend_pri_num : pri_num; // RQ15
    next_pri_den = apply_ok ? next_pend_pri_den : pri_den; // RQ15
    if (init_cmd) begin
      next_pri_num = ENC_COUNTS; // RQ4
      next_pri_den = DEN_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pend_pri_num <= NUM_RST; // RQ1
      pend_pri_den <= DEN_RST; // RQ2
      pri_num <= NUM_RST; // RQ18
      pri_den <= DEN_RST;
      sec_num <= NUM_RST; // RQ16
      sec_den <= DEN_RST;
      ratio_update_policy <= POLICY_RST;
      clear_input_assignment <= CLR_SEL_RST;
    end else begin
      pend_pri_num <= next_pend_pri_num;
      pend_pri_den <= next_pend_pri_den;
      pri_num <= next_pri_num;
      pri_den <= next_pri_den;
      sec_num <= next_sec_num;
      sec_den <= next_sec_den;
      ratio_update_policy <= next_policy;
      clear_input_assignment <= next_clr_sel;
    end
  end

  // counters; the clear edge beats any count in the same cycle
  always_comb begin
    next_cmd_cnt = cmd_cnt;
    next_fb_cnt = fb_cnt;
    next_enc_cnt = enc_cnt;
    if (gear_pulse) begin
      next_cmd_cnt = gear_dir ? cmd_cnt - CNT_ONE : cmd_cnt + CNT_ONE; // RQ10
    end
    if (fb_pulse_i) begin
      next_fb_cnt = fb_dir_i ? fb_cnt - CNT_ONE : fb_cnt + CNT_ONE;
      next_enc_cnt = fb_dir_i ? enc_cnt - CNT_ONE : enc_cnt + CNT_ONE;
    end
    if (clr_fall) begin
      next_cmd_cnt = '0; // RQ7
      next_fb_cnt = '0; // RQ7
      next_enc_cnt = '0; // RQ7
    end
    // error in whole counts, no fraction kept here
    next_err = next_cmd_cnt - next_fb_cnt; // RQ6
    next_command_pulse_inhibit_input_active = command_pulse_inhibit_input_on;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmd_cnt <= '0; // RQ18
      fb_cnt <= '0;
      enc_cnt <= '0;
      pos_error_o <= '0;
      clr_prev <= 1'b0;
      pos_count_pulse_o <= 1'b0;
      pos_count_dir_o <= 1'b0;
      inhibit_active_o <= 1'b0;
    end else begin
      cmd_cnt <= next_cmd_cnt;
      fb_cnt <= next_fb_cnt;
      enc_cnt <= next_enc_cnt;
      pos_error_o <= next_err; // RQ7
      clr_prev <= clr_level; // RQ8
      pos_count_pulse_o <= gear_pulse;
      pos_count_dir_o <= gear_dir;
      inhibit_active_o <= next_command_pulse_inhibit_input_active;
    end
  end

  // read mux, unmapped addresses read zero and flag an error
  always_comb begin
    rd_data = '0;
    addr_hit = 1'b1;
    case (apb_req_i.paddr)
      OFS_CTRL: rd_data[CTRL_POLICY_BIT] = ratio_update_policy;
      OFS_PRI_NUM: rd_data[NUM_W-1:0] = pend_pri_num;
      OFS_PRI_DEN: rd_data[NUM_W-1:0] = pend_pri_den;
      OFS_SEC_NUM: rd_data[NUM_W-1:0] = sec_num;
      OFS_SEC_DEN: rd_data[NUM_W-1:0] = sec_den;
      OFS_CLR_SEL: rd_data[SEL_W-1:0] = clear_input_assignment;
      OFS_STATUS: begin
        rd_data[STAT_COMMAND_PULSE_INHIBIT_INPUT_BIT] = command_pulse_inhibit_input_on;
        rd_data[STAT_SEC_BIT] = use_sec;
        rd_data[STAT_PEND_BIT] = (pend_pri_num != pri_num) | (pend_pri_den != pri_den);
      end
      OFS_CMD_CNT: rd_data = cmd_cnt;
      OFS_FB_CNT: rd_data = fb_cnt;
      OFS_ERR_CNT: rd_data = pos_error_o;
      OFS_ENC_CNT: rd_data = enc_cnt;
      default: addr_hit = 1'b0;
    endcase
  end

  // answer is built in setup and stands one cycle in access
  always_comb begin
    next_pready = apb_req_i.psel & ~apb_req_i.penable;
    next_pslverr = apb_req_i.psel & ~apb_req_i.penable & ~addr_hit;
    next_prdata = apb_rsp_o.prdata;
    if (apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite) begin
      next_prdata = rd_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o.pready <= next_pready;
      apb_rsp_o.pslverr <= next_pslverr;
      apb_rsp_o.prdata <= next_prdata;
    end
  end

endmodule : prs_pulse_scaler

// [design/prs_pkg.sv]
package prs_pkg;

  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int COMMAND_PULSE_INHIBIT_INPUT_DELAY_MS = 10; // inhibit_response_delay, in ms
  // 10 ms at 50 MHz is 500000 cycles
  localparam int COMMAND_PULSE_INHIBIT_INPUT_DELAY_CYC = COMMAND_PULSE_INHIBIT_INPUT_DELAY_MS * (CLK_HZ / 1000);

  // widths
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NUM_W = 16;
  localparam int CNT_W = 32;
  localparam int ACC_W = 40;
  localparam int SEL_W = 3;

  // reset values of the ratio pairs and controls, and the numerator loaded by initialise
  localparam logic [15:0] NUM_RST = 16'h0004;
  localparam logic [15:0] DEN_RST = 16'h0001;
  localparam logic [15:0] ENC_COUNTS_DEF = 16'h2000; // counts per turn of the fitted encoder
  localparam logic POLICY_RST = 1'b0;
  localparam logic [SEL_W-1:0] CLR_SEL_RST = 3'h0;

  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_PRI_NUM = 8'h04;
  localparam logic [AW-1:0] OFS_PRI_DEN = 8'h08;
  localparam logic [AW-1:0] OFS_SEC_NUM = 8'h0C;
  localparam logic [AW-1:0] OFS_SEC_DEN = 8'h10;
  localparam logic [AW-1:0] OFS_CLR_SEL = 8'h14;
  localparam logic [AW-1:0] OFS_STATUS = 8'h18;
  localparam logic [AW-1:0] OFS_CMD_CNT = 8'h1C;
  localparam logic [AW-1:0] OFS_FB_CNT = 8'h20;
  localparam logic [AW-1:0] OFS_ERR_CNT = 8'h24;
  localparam logic [AW-1:0] OFS_ENC_CNT = 8'h28;

  // field positions
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_POLICY_BIT = 1;
  localparam int STAT_COMMAND_PULSE_INHIBIT_INPUT_BIT = 0;
  localparam int STAT_SEC_BIT = 1;
  localparam int STAT_PEND_BIT = 2;

  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } prs_apb_req_t;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } prs_apb_rsp_t;

endpackage : prs_pkg

// [design/prs_level_delay.sv]
`timescale 1ns/1ps
// output follows the input once it has stood changed for DELAY_CYC cycles
module prs_level_delay #(
  parameter int DELAY_CYC = 500000
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic level_o
);
  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt; // cycles the input has differed
  logic [CW-1:0] next_cnt;
  logic next_level;

  // a short glitch restarts the count, so only a settled change passes
  always_comb begin
    next_cnt = '0;
    next_level = level_o;
    if (level_i != level_o) begin
      if (cnt == LAST) begin
        next_level = level_i;
      end else begin
        next_cnt = cnt + ONE;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      level_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      level_o <= next_level;
    end
  end

endmodule : prs_level_delay

// [design/prs_gear_accum.sv]
`timescale 1ns/1ps
// numerator per input pulse in, one count per denominator out
module prs_gear_accum #(
  parameter int NUM_W = 16,
  parameter int ACC_W = 40
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pulse_i, // accepted command pulse
  input wire logic dir_i, // 1 = reverse
  input wire logic [NUM_W-1:0] num_i,
  input wire logic [NUM_W-1:0] den_i,
  input wire logic clr_i, // drops the remainder
  output logic cnt_pulse_o,
  output logic cnt_dir_o
);
  logic signed [ACC_W-1:0] acc; // signed remainder in numerator units
  logic signed [ACC_W-1:0] next_acc;
  logic signed [ACC_W-1:0] num_ext;
  logic signed [ACC_W-1:0] den_ext;
  logic next_pulse;
  logic next_dir;

  assign num_ext = $signed({{(ACC_W-NUM_W){1'b0}}, num_i});
  assign den_ext = $signed({{(ACC_W-NUM_W){1'b0}}, den_i});

  // one count per cycle; a big ratio drains over several cycles but
  // the remainder keeps every fraction, so nothing is lost
  always_comb begin
    next_acc = acc;
    next_pulse = 1'b0;
    next_dir = cnt_dir_o;
    if (acc >= den_ext) begin
      next_acc = acc - den_ext; // RQ17
      next_pulse = 1'b1;
      next_dir = 1'b0;
    end else if (acc <= -den_ext) begin
      next_acc = acc + den_ext; // RQ17
      next_pulse = 1'b1;
      next_dir = 1'b1;
    end
    if (pulse_i) begin
      next_acc = dir_i ? next_acc - num_ext : next_acc + num_ext; // RQ17
    end
    if (clr_i) begin
      next_acc = '0;
      next_pulse = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc <= '0; // RQ18
      cnt_pulse_o <= 1'b0;
      cnt_dir_o <= 1'b0;
    end else begin
      acc <= next_acc;
      cnt_pulse_o <= next_pulse;
      cnt_dir_o <= next_dir;
    end
  end

endmodule : prs_gear_accum

// [verif/prs_host_model.sv]
`timescale 1ns/1ps
// host controller stand-in: issues command steps, tight or spaced
module prs_host_model (
  input wire logic ref_clk_i,
  output logic cmd_pulse_o,
  output logic cmd_dir_o
);
  initial begin
    cmd_pulse_o = 1'b0;
    cmd_dir_o = 1'b0;
  end

  // n steps, gap idle cycles after each; gap 0 gives one step per cycle
  task automatic send(input int n, input logic dir, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      cmd_pulse_o <= 1'b1;
      cmd_dir_o <= dir;
      repeat (gap) begin
        @(posedge ref_clk_i);
        cmd_pulse_o <= 1'b0;
        cmd_dir_o <= ~dir; // idle direction flipped so nothing leans on it
      end
    end
    @(posedge ref_clk_i);
    cmd_pulse_o <= 1'b0;
    cmd_dir_o <= ~dir;
  endtask : send
endmodule : prs_host_model

// [verif/prs_pulse_scaler_monitor.sv]
`timescale 1ns/1ps
// port watcher for the ratio scaler
module prs_pulse_scaler_monitor
  import prs_pkg::*;
#(
  parameter int SEQ_N = 8,
  parameter int COMMAND_PULSE_INHIBIT_INPUT_CYC = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire prs_pkg::prs_apb_req_t apb_req_i,
  input wire prs_pkg::prs_apb_rsp_t apb_rsp_o,
  input wire logic command_pulse_inhibit_input_i,
  input wire logic [SEQ_N-1:0] seq_in_i,
  input wire logic pos_count_pulse_o,
  input wire logic [prs_pkg::CNT_W-1:0] pos_error_o,
  input wire logic inhibit_active_o
);
  logic [19:0] hi_cnt; // cycles the inhibit level has stood high
  logic [19:0] next_hi_cnt;

  // saturating run length, so a long inhibit never wraps to zero
  always_comb begin
    next_hi_cnt = command_pulse_inhibit_input_i ? hi_cnt + 20'h1 : 20'h0;
    if (command_pulse_inhibit_input_i && hi_cnt == 20'hFFFFF) next_hi_cnt = hi_cnt;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) hi_cnt <= 20'h0;
    else hi_cnt <= next_hi_cnt;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // apb phases
  sequence s_setup;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence
  sequence s_answer;
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
  endsequence

  property p_ready; s_setup |=> s_answer; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_ready_once; apb_rsp_o.pready |-> s_answer ##1 !apb_rsp_o.pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready stray or long");
  property p_err_map; apb_rsp_o.pready && apb_req_i.paddr > OFS_ENC_CNT |-> apb_rsp_o.pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped address accepted");
  property p_ok_map;
    apb_rsp_o.pready && apb_req_i.paddr <= OFS_ENC_CNT && apb_req_i.paddr[1:0] == 2'h0
      |-> !apb_rsp_o.pslverr;
  endproperty
  a_ok_map: assert property (p_ok_map) else $error("mapped address refused");
  property p_rdata_hold;
    !(apb_req_i.psel && !apb_req_i.penable && !apb_req_i.pwrite) |=> $stable(apb_rsp_o.prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_rst_out;
    $rose(rst_n_i) |-> pos_error_o == '0 && !pos_count_pulse_o && !apb_rsp_o.pready;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  property p_clear; $fell(seq_in_i[0]) |-> ##[1:2] pos_error_o == '0; endproperty
  a_clear: assert property (p_clear) else $error("error not cleared on fall");
  property p_command_pulse_inhibit_input_delay; $rose(inhibit_active_o) |-> hi_cnt >= COMMAND_PULSE_INHIBIT_INPUT_CYC; endproperty
  a_command_pulse_inhibit_input_delay: assert property (p_command_pulse_inhibit_input_delay) else $error("inhibit acted early");
endmodule : prs_pulse_scaler_monitor

bind prs_pulse_scaler prs_pulse_scaler_monitor #(.SEQ_N(SEQ_N), .COMMAND_PULSE_INHIBIT_INPUT_CYC(COMMAND_PULSE_INHIBIT_INPUT_CYC)) mon (
  .ref_clk_i, .rst_n_i, .apb_req_i, .apb_rsp_o, .command_pulse_inhibit_input_i, .seq_in_i,
  .pos_count_pulse_o, .pos_error_o, .inhibit_active_o
);

// [verif/prs_pulse_scaler_bench.sv]
`timescale 1ns/1ps
`define PRS_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module prs_pulse_scaler_bench;
  import prs_pkg::*;
  localparam int COMMAND_PULSE_INHIBIT_INPUT = 8; // short inhibit delay keeps the run brief
  localparam logic [15:0] ENC = 16'h0123; // encoder counts, arbitrary
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  prs_apb_req_t req = '0; // apb request
  prs_apb_rsp_t rsp; // apb answer
  logic cmd_pulse;
  logic cmd_dir;
  logic fb_pulse = 1'b0;
  logic fb_dir = 1'b0; // feedback step direction
  logic pos_mode = 1'b1;
  logic servo_on = 1'b0;
  logic command_pulse_inhibit_input = 1'b0;
  logic ratio_sel = 1'b0;
  logic [7:0] seq = 8'h00; // bit 0 carries the clear
  logic cnt_pulse;
  logic cnt_dir; // direction of each scaled count
  logic [31:0] pos_err;
  logic command_pulse_inhibit_input_act;
  logic [31:0] q;
  logic e;
  int err_total = 0;
  int total_checks = 0;
  int n_cnt = 0; // scaled counts seen
  int n_rev = 0; // scaled counts seen in reverse
  int exp_err = 0; // expected position error
  int cyc = 0;

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  prs_pulse_scaler #(.COMMAND_PULSE_INHIBIT_INPUT_CYC(COMMAND_PULSE_INHIBIT_INPUT), .ENC_COUNTS(ENC)) dut (
    .ref_clk_i, .rst_n_i, .apb_req_i(req), .apb_rsp_o(rsp), .cmd_pulse_i(cmd_pulse),
    .cmd_dir_i(cmd_dir), .fb_pulse_i(fb_pulse), .fb_dir_i(fb_dir), .pos_mode_i(pos_mode),
    .servo_on_i(servo_on), .command_pulse_inhibit_input_i(command_pulse_inhibit_input),
    .ratio_set_select_i(ratio_sel), .seq_in_i(seq), .pos_count_pulse_o(cnt_pulse),
    .pos_count_dir_o(cnt_dir), .pos_error_o(pos_err), .inhibit_active_o(command_pulse_inhibit_input_act)
  );

  prs_host_model host (.ref_clk_i, .cmd_pulse_o(cmd_pulse), .cmd_dir_o(cmd_dir));

  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // count scaled outputs; hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cnt_pulse === 1'b1) n_cnt <= n_cnt + 1;
    if (cnt_pulse === 1'b1 && cnt_dir === 1'b1) n_rev <= n_rev + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    do @(posedge ref_clk_i); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `PRS_CHK(q, x)
  endtask : rd_chk

  // send steps, wait for the scaled counts, compare count and error
  task automatic run(input int n, input logic dir, input int gap, input int x);
    int base;
    int rbase;
    int k;
    base = n_cnt;
    rbase = n_rev;
    host.send(n, dir, gap);
    k = 0;
    while (n_cnt - base != x && k < 400) begin
      @(posedge ref_clk_i);
      k++;
    end
    repeat (6) @(posedge ref_clk_i); // late extras would show here
    exp_err += dir ? -x : x;
    `PRS_CHK(n_cnt - base, x)
    `PRS_CHK(pos_err, 32'(exp_err))
    `PRS_CHK(n_rev - rbase, dir ? x : 0)
  endtask : run

  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd_chk(OFS_PRI_NUM, 32'h4);
    rd_chk(OFS_PRI_DEN, 32'h1);
    rd_chk(OFS_SEC_NUM, 32'h4);
    rd_chk(OFS_SEC_DEN, 32'h1);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_CMD_CNT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `PRS_CHK(e, 1'b1)
    run(1, 1'b0, 0, 4);
    run(3, 1'b0, 0, 12);
    run(2, 1'b1, 1, 8);
    wr(OFS_PRI_NUM, 32'h3);
    wr(OFS_PRI_DEN, 32'h2);
    run(1, 1'b0, 2, 1);
    run(1, 1'b0, 2, 2);
    wr(OFS_PRI_DEN, 32'h0);
    rd_chk(OFS_PRI_DEN, 32'h2);
    wr(OFS_SEC_NUM, 32'h5);
    ratio_sel <= 1'b1;
    run(1, 1'b0, 1, 5);
    ratio_sel <= 1'b0;
    servo_on <= 1'b1;
    wr(OFS_PRI_NUM, 32'h1);
    rd_chk(OFS_STATUS, 32'h4);
    run(2, 1'b0, 2, 3);
    servo_on <= 1'b0;
    rd_chk(OFS_STATUS, 32'h0);
    run(2, 1'b0, 2, 1);
    wr(OFS_CTRL, 32'h2);
    servo_on <= 1'b1;
    wr(OFS_PRI_DEN, 32'h1);
    run(1, 1'b0, 2, 1);
    servo_on <= 1'b0;
    pos_mode <= 1'b0;
    run(3, 1'b0, 0, 0);
    pos_mode <= 1'b1;
    command_pulse_inhibit_input <= 1'b1;
    repeat (COMMAND_PULSE_INHIBIT_INPUT - 2) @(posedge ref_clk_i);
    `PRS_CHK(command_pulse_inhibit_input_act, 1'b0)
    repeat (6) @(posedge ref_clk_i);
    `PRS_CHK(command_pulse_inhibit_input_act, 1'b1)
    rd_chk(OFS_STATUS, 32'h1);
    run(3, 1'b0, 0, 0);
    command_pulse_inhibit_input <= 1'b0;
    repeat (COMMAND_PULSE_INHIBIT_INPUT - 2) @(posedge ref_clk_i);
    `PRS_CHK(command_pulse_inhibit_input_act, 1'b1)
    repeat (6) @(posedge ref_clk_i);
    `PRS_CHK(command_pulse_inhibit_input_act, 1'b0)
    run(1, 1'b0, 0, 1);
    // feedback steps, then a clear held high before it falls
    fb_pulse <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    fb_pulse <= 1'b0;
    exp_err -= 3;
    seq <= 8'h01;
    run(1, 1'b0, 0, 1);
    rd_chk(OFS_FB_CNT, 32'h3);
    seq <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
    `PRS_CHK(pos_err, 32'h0)
    rd_chk(OFS_CMD_CNT, 32'h0);
    rd_chk(OFS_FB_CNT, 32'h0);
    rd_chk(OFS_ENC_CNT, 32'h0);
    exp_err = 0;
    // clear moved to sequence input 2, with one reverse feedback step
    wr(OFS_CLR_SEL, 32'h2);
    rd_chk(OFS_CLR_SEL, 32'h2);
    fb_dir <= 1'b1;
    fb_pulse <= 1'b1;
    seq <= 8'h04;
    @(posedge ref_clk_i);
    fb_pulse <= 1'b0;
    exp_err += 1;
    run(1, 1'b0, 0, 1);
    rd_chk(OFS_ENC_CNT, 32'hFFFFFFFF);
    seq <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
    `PRS_CHK(pos_err, 32'h0)
    rd_chk(OFS_ENC_CNT, 32'h0);
    exp_err = 0;
    wr(OFS_CTRL, 32'h1);
    rd_chk(OFS_PRI_NUM, 32'(ENC));
    rd_chk(OFS_CTRL, 32'h0);
    run(1, 1'b0, 0, int'(ENC));
    finish_test();
  end
endmodule : prs_pulse_scaler_bench
